/* File: hw/dpsb_pkg.sv */
// dpsb_pkg: constants shared by the data pre-fetch stream buffer files
// assumes one core clock and active-low asynchronous reset
// Functional notes
// - pre-fetch lines are 128 bytes, each seen as two 64-byte halves
// - level-2 request consumes a whole line, level-1 request one half
// - level-1 hit on a stream may re-fetch the other half of that line
// - half-line re-fetch only in level-1 mode, never from level-2 accesses while level-2 is active
// - eight entries 0..7, each tracks an address and the next 64 bytes
// - with all entries in use a new stream takes the oldest entry
// - new stream after read X pre-fetches X+64, then X+128 next cycle
// - reallocation marks old outstanding pre-fetches stale, returns dropped
// - one valid outstanding pre-fetch per slot, even on same-edge moves
// - stalled pre-fetch stays held and is forwarded to memory later
// - cleared region enable stops pre-fetch, level-1 caching unaffected
// - enable bits of attribute registers 12..15 reset to one
// - attribute registers accept writes only in supervisor mode
// - level-2 off, zero size or frozen gives level-1 half behaviour
// - only cacheable data bypassing level-2 uses halves, no program fetch
package dpsb_pkg;
    localparam int ADDR_W = 32;
    localparam int LINE_BYTES = 128;
    localparam int HALF_BYTES = 64;
    localparam int HALF_SHIFT = $clog2(HALF_BYTES);
    localparam int NUM_ENTRIES = 8;
    localparam int GEN_WIDTH = 4;
    localparam int NUM_MAR = 16;
    localparam int MAR_IDX_W = $clog2(NUM_MAR);
    localparam int MAR_SHIFT = 24;
    localparam logic [NUM_MAR-1:0] MAR_PFX_RST = 16'hF000;
endpackage : dpsb_pkg

/* File: hw/dpsb_attr.sv */
// dpsb_attr: pre-fetch enable bits of the memory attribute registers
// assumes write strobes come from core logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module dpsb_attr
    import dpsb_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [MAR_IDX_W-1:0] wr_idx_i,
    input wire logic wr_pfx_i,
    input wire logic supervisor_i,
    output logic [NUM_MAR-1:0] pfx_o
);
    logic [NUM_MAR-1:0] pfx_r;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pfx_r <= MAR_PFX_RST;
        end
        else if (ce_i && wr_en_i && supervisor_i)
        begin
            pfx_r[wr_idx_i] <= wr_pfx_i;
        end
    end

    assign pfx_o = pfx_r;

    a_user_write_ignored: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        wr_en_i && !supervisor_i |=> $stable(pfx_r))
        else $error("attribute changed by a user-mode write");

    a_super_write_takes: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        ce_i && wr_en_i && supervisor_i |=> pfx_r[$past(wr_idx_i)]
            == $past(wr_pfx_i))
        else $error("supervisor write to attribute not stored");
endmodule : dpsb_attr
`default_nettype wire

/* File: hw/dpsb_top.sv */
// dpsb_top: data pre-fetch stream buffer tracking, issue and stale sorting
// assumes requesters and shared memory controller share clk_i
`timescale 1ns/1ps
`default_nettype none
module dpsb_top
    import dpsb_pkg::*;
#(
    parameter int ENTRIES = NUM_ENTRIES,
    parameter int GEN_W = GEN_WIDTH
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic rd_valid_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    input wire logic rd_src_l2_i,
    input wire logic rd_prog_i,
    input wire logic l2_active_i,
    output logic rd_ready_o,
    output logic rsp_valid_o,
    output logic rsp_hit_o,
    output logic mem_req_valid_o,
    output logic [ADDR_W-1:0] mem_req_addr_o,
    output logic [$clog2(2*ENTRIES)+GEN_W-1:0] mem_req_tag_o,
    input wire logic mem_ready_i,
    input wire logic ret_valid_i,
    input wire logic [$clog2(2*ENTRIES)+GEN_W-1:0] ret_tag_i,
    input wire logic ret_cancel_i,
    input wire logic mar_wr_en_i,
    input wire logic [MAR_IDX_W-1:0] mar_wr_idx_i,
    input wire logic mar_wr_pfx_i,
    input wire logic supervisor_i
);
    localparam int EW = $clog2(ENTRIES);
    localparam int SLOTS = 2 * ENTRIES;
    localparam int SW = EW + 1;
    localparam int TW = SW + GEN_W;
    localparam int BLK_W = ADDR_W - HALF_SHIFT;

    logic [NUM_MAR-1:0] prefetch_enable_bit;
    logic [BLK_W-1:0] start_r [ENTRIES];
    logic [ENTRIES-1:0] ent_v_r;
    logic [SLOTS-1:0] pres_r;
    logic [SLOTS-1:0] pend_r;
    logic [GEN_W-1:0] gen_r [SLOTS];
    logic [EW-1:0] alloc_ptr_r;
    logic out_v_r;
    logic [ADDR_W-1:0] out_addr_r;
    logic [TW-1:0] out_tag_r;
    logic sec_v_r;
    logic [ADDR_W-1:0] sec_addr_r;
    logic [TW-1:0] sec_tag_r;
    logic rd_ready_r;
    logic rsp_v_r;
    logic rsp_hit_r;

    logic acc;
    logic [BLK_W-1:0] blk;
    logic in_map;
    logic pf_ok;
    logic l1_mode;
    logic hit;
    logic [EW-1:0] hit_e;
    logic hit_h;
    logic [SW-1:0] hs;
    logic [SW-1:0] os;
    logic demand_hit;
    logic do_refetch;
    logic do_adv;
    logic do_alloc;
    logic [EW-1:0] tgt_e;
    logic [BLK_W-1:0] f_blk;
    logic [SW-1:0] f_slot;
    logic [GEN_W-1:0] f_gen;
    logic [GEN_W-1:0] s_gen;
    logic [SW-1:0] ret_slot;
    logic [GEN_W-1:0] ret_gen;
    logic ret_match;
    logic out_load;
    logic out_v_nxt;
    logic sec_v_nxt;

    dpsb_attr u_attr (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .wr_en_i(mar_wr_en_i),
        .wr_idx_i(mar_wr_idx_i),
        .wr_pfx_i(mar_wr_pfx_i),
        .supervisor_i(supervisor_i),
        .pfx_o(prefetch_enable_bit)
    );

    // request classification and stream lookup
    always_comb
    begin
        acc = ce_i && rd_valid_i && rd_ready_r;
        blk = rd_addr_i[ADDR_W-1:HALF_SHIFT];
        in_map = rd_addr_i[ADDR_W-1:MAR_SHIFT+MAR_IDX_W] == '0;
        pf_ok = !rd_prog_i && in_map
            && prefetch_enable_bit[rd_addr_i[MAR_SHIFT +: MAR_IDX_W]];
        l1_mode = !rd_src_l2_i || !l2_active_i;
        hit = 1'b0;
        hit_e = '0;
        hit_h = 1'b0;
        for (int e = ENTRIES - 1; e >= 0; e--)
        begin
            if (ent_v_r[e] && blk == start_r[e])
            begin
                hit = 1'b1;
                hit_e = EW'(e);
                hit_h = 1'b0;
            end
            else if (ent_v_r[e] && blk == BLK_W'(start_r[e] + 1'b1))
            begin
                hit = 1'b1;
                hit_e = EW'(e);
                hit_h = 1'b1;
            end
        end
        hs = {hit_e, hit_h};
        os = {hit_e, ~hit_h};
        if (l1_mode)
        begin
            demand_hit = pres_r[hs];
        end
        else
        begin
            demand_hit = pres_r[{hit_e, 1'b0}] && pres_r[{hit_e, 1'b1}];
        end
        do_refetch = acc && pf_ok && hit && l1_mode
            && !pres_r[os] && !pend_r[os];
        do_adv = acc && pf_ok && hit && !l1_mode && demand_hit;
        do_alloc = acc && pf_ok && !hit;
        tgt_e = do_alloc ? alloc_ptr_r : hit_e;
        if (do_refetch)
        begin
            f_blk = hit_h ? BLK_W'(blk - 1'b1) : BLK_W'(blk + 1'b1);
            f_slot = os;
        end
        else if (do_adv)
        begin
            f_blk = BLK_W'(start_r[hit_e] + 2'd2);
            f_slot = {hit_e, 1'b0};
        end
        else
        begin
            f_blk = BLK_W'(blk + 1'b1);
            f_slot = {tgt_e, 1'b0};
        end
        f_gen = do_alloc ? GEN_W'(gen_r[f_slot] + 1'b1) : gen_r[f_slot];
        s_gen = do_alloc ? GEN_W'(gen_r[{tgt_e, 1'b1}] + 1'b1)
            : gen_r[{tgt_e, 1'b1}];
        ret_slot = ret_tag_i[TW-1:GEN_W];
        ret_gen = ret_tag_i[GEN_W-1:0];
        ret_match = ret_valid_i && pend_r[ret_slot]
            && gen_r[ret_slot] == ret_gen;
        out_load = !out_v_r || mem_ready_i;
        if (out_load)
        begin
            out_v_nxt = sec_v_r || do_refetch || do_adv || do_alloc;
            sec_v_nxt = !sec_v_r && (do_adv || do_alloc);
        end
        else
        begin
            out_v_nxt = out_v_r;
            sec_v_nxt = sec_v_r;
        end
    end

    // entry tags, validity and allocation pointer
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ent_v_r <= '0;
            alloc_ptr_r <= '0;
            for (int e = 0; e < ENTRIES; e++)
            begin
                start_r[e] <= '0;
            end
        end
        else if (ce_i)
        begin
            if (do_alloc)
            begin
                ent_v_r[alloc_ptr_r] <= 1'b1;
                start_r[alloc_ptr_r] <= BLK_W'(blk + 1'b1);
                alloc_ptr_r <= EW'(alloc_ptr_r + 1'b1);
            end
            else if (do_adv)
            begin
                start_r[hit_e] <= BLK_W'(start_r[hit_e] + 2'd2);
            end
        end
    end

    // per-slot data presence, outstanding flag and generation
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pres_r <= '0;
            pend_r <= '0;
            for (int s = 0; s < SLOTS; s++)
            begin
                gen_r[s] <= '0;
            end
        end
        else if (ce_i)
        begin
            if (ret_match)
            begin
                pend_r[ret_slot] <= 1'b0;
                pres_r[ret_slot] <= !ret_cancel_i;
            end
            if (acc && pf_ok && hit && demand_hit && l1_mode)
            begin
                pres_r[hs] <= 1'b0;
            end
            if (do_refetch)
            begin
                pend_r[os] <= 1'b1;
            end
            if (do_adv || do_alloc)
            begin
                pres_r[{tgt_e, 1'b0}] <= 1'b0;
                pres_r[{tgt_e, 1'b1}] <= 1'b0;
                pend_r[{tgt_e, 1'b0}] <= 1'b1;
                pend_r[{tgt_e, 1'b1}] <= 1'b1;
                gen_r[{tgt_e, 1'b0}] <= f_gen;
                gen_r[{tgt_e, 1'b1}] <= s_gen;
            end
        end
    end

    // two-deep issue stage towards the shared memory controller
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            out_v_r <= 1'b0;
            out_addr_r <= '0;
            out_tag_r <= '0;
            sec_v_r <= 1'b0;
            sec_addr_r <= '0;
            sec_tag_r <= '0;
        end
        else if (ce_i)
        begin
            out_v_r <= out_v_nxt;
            sec_v_r <= sec_v_nxt;
            if (out_load && sec_v_r)
            begin
                out_addr_r <= sec_addr_r;
                out_tag_r <= sec_tag_r;
            end
            else if (out_load && (do_refetch || do_adv || do_alloc))
            begin
                out_addr_r <= {f_blk, {HALF_SHIFT{1'b0}}};
                out_tag_r <= {f_slot, f_gen};
                sec_addr_r <= {BLK_W'(f_blk + 1'b1), {HALF_SHIFT{1'b0}}};
                sec_tag_r <= {tgt_e, 1'b1, s_gen};
            end
        end
    end

    // read handshake and demand response
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_ready_r <= 1'b0;
            rsp_v_r <= 1'b0;
            rsp_hit_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rd_ready_r <= !out_v_nxt && !sec_v_nxt && !acc;
            rsp_v_r <= acc;
            rsp_hit_r <= acc && pf_ok && hit && demand_hit;
        end
    end

    assign rd_ready_o = rd_ready_r;
    assign rsp_valid_o = rsp_v_r;
    assign rsp_hit_o = rsp_hit_r;
    assign mem_req_valid_o = out_v_r;
    assign mem_req_addr_o = out_addr_r;
    assign mem_req_tag_o = out_tag_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_new_stream_pair: assert property (do_alloc
        |=> out_v_r && out_addr_r[ADDR_W-1:HALF_SHIFT] == $past(blk) + 1'b1
        ##1 out_v_r && (sec_v_r || out_addr_r[ADDR_W-1:HALF_SHIFT]
        == $past(blk, 2) + 2'd2))
        else $error("new stream pre-fetch pair wrong");

    a_stall_holds: assert property (out_v_r && !mem_ready_i
        |=> out_v_r && $stable(out_addr_r) && $stable(out_tag_r))
        else $error("stalled pre-fetch dropped or changed");

    a_l2_no_refetch: assert property (acc && rd_src_l2_i && l2_active_i
        |=> !out_v_r || sec_v_r)
        else $error("re-fetch from level-2 access");

    a_region_off: assert property (acc && !pf_ok
        |=> !out_v_r && !rsp_hit_o)
        else $error("pre-fetch issued for disabled region");

    a_oldest_victim: assert property (do_alloc
        |=> alloc_ptr_r == EW'($past(alloc_ptr_r) + 1'b1)
        && ent_v_r[$past(alloc_ptr_r)])
        else $error("allocation skipped oldest entry");

    a_stale_dropped: assert property (ret_valid_i && !ret_match
        && !acc |=> $stable(pres_r) && $stable(pend_r))
        else $error("stale return changed slot state");

    a_gen_bumped: assert property (do_alloc
        |=> gen_r[{$past(tgt_e), 1'b0}] != $past(gen_r[{tgt_e, 1'b0}])
        && gen_r[{$past(tgt_e), 1'b1}]
        != $past(gen_r[{tgt_e, 1'b1}]))
        else $error("reallocation left old generation valid");

    a_cancel_misses: assert property (ret_match && ret_cancel_i && !acc
        |=> !pres_r[$past(ret_slot)])
        else $error("cancelled pre-fetch marked present");

    a_half_consume: assert property (acc && pf_ok && hit && l1_mode
        && demand_hit |=> rsp_hit_o && !pres_r[$past(hs)])
        else $error("level-1 hit did not consume its half");
endmodule : dpsb_top
`default_nettype wire

/* File: verification/dpsb_mem_model.sv */
// dpsb_mem_model: shared memory controller stand-in for pre-fetches
// assumes the block's request port runs on the same clock
`timescale 1ns/1ps
`default_nettype none
module dpsb_mem_model
    import dpsb_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [7:0] req_tag_i,
    input wire logic stall_i,
    input wire logic go_i,
    input wire logic cancel_i,
    output logic ready_o,
    output logic ret_valid_o,
    output logic [7:0] ret_tag_o,
    output logic ret_cancel_o,
    output int cnt_o,
    output logic [ADDR_W-1:0] last_o,
    output logic [ADDR_W-1:0] prev_o
);
    logic [7:0] q[$];
    // taken tags wait in order; go_i lets one return out per cycle
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q.delete();
            ready_o <= 1'b0;
            ret_valid_o <= 1'b0;
            ret_tag_o <= 8'h00;
            ret_cancel_o <= 1'b0;
            cnt_o <= 0;
            last_o <= '0;
            prev_o <= '0;
        end
        else
        begin
            ready_o <= !stall_i;
            if (req_valid_i && ready_o)
            begin
                q.push_back(req_tag_i);
                cnt_o <= cnt_o + 1;
                prev_o <= last_o;
                last_o <= req_addr_i;
            end
            if (go_i && q.size() > 0)
            begin
                ret_valid_o <= 1'b1;
                ret_tag_o <= q.pop_front();
                ret_cancel_o <= cancel_i;
            end
            else
            begin
                // idle return lines wander so no old tag lingers
                ret_valid_o <= 1'b0;
                ret_tag_o <= ~ret_tag_o;
                ret_cancel_o <= ~ret_cancel_o;
            end
        end
    end
endmodule : dpsb_mem_model
`default_nettype wire

/* File: verification/dpsb_tb_top.sv */
// dpsb_tb_top: self-checking bench for the pre-fetch stream buffer
// assumes dpsb_top with default parameters and the memory model
`timescale 1ns/1ps
`default_nettype none
module dpsb_tb_top;
    import dpsb_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rd_valid_i = 1'b0;
    logic [ADDR_W-1:0] rd_addr_i = '0;
    logic rd_src_l2_i = 1'b0;
    logic rd_prog_i = 1'b0;
    logic l2_active_i = 1'b1;
    logic mar_wr_en_i = 1'b0;
    logic [MAR_IDX_W-1:0] mar_wr_idx_i = '0;
    logic mar_wr_pfx_i = 1'b0;
    logic supervisor_i = 1'b1;
    logic stall = 1'b0;
    logic go = 1'b1;
    logic cancel = 1'b0;
    logic rd_ready_o, rsp_valid_o, rsp_hit_o, mem_req_valid_o;
    logic mem_ready_i, ret_valid_i, ret_cancel_i, hit;
    logic [ADDR_W-1:0] mem_req_addr_o, last, prev;
    logic [7:0] mem_req_tag_o, ret_tag_i;
    int cnt, c0 = 0, miscompares = 0, checked = 0;
    localparam logic [31:0] X = 32'h0C000000;
    localparam logic [31:0] Y = 32'h0D000000;
    localparam logic [31:0] P = 32'h0E000000;

    always #2.5 clk_i = ~clk_i;

    dpsb_top dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .rd_valid_i(rd_valid_i), .rd_addr_i(rd_addr_i),
        .rd_src_l2_i(rd_src_l2_i), .rd_prog_i(rd_prog_i),
        .l2_active_i(l2_active_i), .rd_ready_o(rd_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_hit_o(rsp_hit_o),
        .mem_req_valid_o(mem_req_valid_o), .mem_req_addr_o(mem_req_addr_o),
        .mem_req_tag_o(mem_req_tag_o), .mem_ready_i(mem_ready_i),
        .ret_valid_i(ret_valid_i), .ret_tag_i(ret_tag_i),
        .ret_cancel_i(ret_cancel_i), .mar_wr_en_i(mar_wr_en_i),
        .mar_wr_idx_i(mar_wr_idx_i), .mar_wr_pfx_i(mar_wr_pfx_i),
        .supervisor_i(supervisor_i)
    );

    dpsb_mem_model mem (
        .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(mem_req_valid_o),
        .req_addr_i(mem_req_addr_o), .req_tag_i(mem_req_tag_o),
        .stall_i(stall), .go_i(go), .cancel_i(cancel),
        .ready_o(mem_ready_i), .ret_valid_o(ret_valid_i),
        .ret_tag_o(ret_tag_i), .ret_cancel_o(ret_cancel_i),
        .cnt_o(cnt), .last_o(last), .prev_o(prev)
    );

    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // one demand read, answer judged, then time for pre-fetch traffic
    task automatic rd(input logic [31:0] a, input logic l2, input logic pg);
        int n;
        n = 0;
        while (rd_ready_o !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        rd_valid_i <= 1'b1;
        rd_addr_i <= a;
        rd_src_l2_i <= l2;
        rd_prog_i <= pg;
        @(posedge clk_i);
        rd_valid_i <= 1'b0;
        @(posedge clk_i);
        chk(rsp_valid_o, 1'b1);
        hit = rsp_hit_o;
        cyc(8);
    endtask : rd

    task automatic req(input int d, input logic [31:0] l, input logic [31:0] p);
        chk(cnt - c0, d);
        if (d > 0)
            chk(last, l);
        if (d > 1)
            chk(prev, p);
        c0 = cnt;
    endtask : req

    task automatic wmar(input logic [3:0] i, input logic v);
        mar_wr_en_i <= 1'b1;
        mar_wr_idx_i <= i;
        mar_wr_pfx_i <= v;
        @(posedge clk_i);
        mar_wr_en_i <= 1'b0;
        @(posedge clk_i);
    endtask : wmar

    task automatic t_l1();
        rd(X, 1'b0, 1'b0);
        chk(hit, 1'b0);
        req(2, X + 128, X + 64);
        rd(X + 64, 1'b0, 1'b0);
        chk(hit, 1'b1);
        req(0, 0, 0);
        rd(X + 128, 1'b0, 1'b0);
        chk(hit, 1'b1);
        req(1, X + 64, 0);
        rd(X + 64, 1'b0, 1'b0);
        chk(hit, 1'b1);
        c0 = cnt;
    endtask : t_l1

    task automatic t_l2();
        rd(Y, 1'b1, 1'b0);
        req(2, Y + 128, Y + 64);
        rd(Y + 64, 1'b1, 1'b0);
        chk(hit, 1'b1);
        req(2, Y + 256, Y + 192);
        l2_active_i <= 1'b0;
        rd(Y + 32'h10000, 1'b1, 1'b0);
        c0 = cnt;
        rd(Y + 32'h10040, 1'b1, 1'b0);
        req(0, 0, 0);
        rd(Y + 32'h10080, 1'b1, 1'b0);
        chk(hit, 1'b1);
        req(1, Y + 32'h10040, 0);
        l2_active_i <= 1'b1;
        rd(X + 32'h200000, 1'b0, 1'b1);
        c0 = cnt;
    endtask : t_l2

    task automatic t_prog_stall();
        c0 = cnt;
        rd(X + 32'h200000, 1'b0, 1'b1);
        chk(hit, 1'b0);
        req(0, 0, 0);
        stall <= 1'b1;
        cyc(2);
        rd(X + 32'h300000, 1'b0, 1'b0);
        cyc(10);
        chk(mem_req_valid_o, 1'b1);
        chk(mem_req_addr_o, X + 32'h300040);
        chk(mem_req_tag_o, 32'h61);
        chk(rd_ready_o, 1'b0);
        req(0, 0, 0);
        stall <= 1'b0;
        cyc(8);
        req(2, X + 32'h300080, X + 32'h300040);
        cancel <= 1'b1;
        rd(X + 32'h400000, 1'b0, 1'b0);
        cancel <= 1'b0;
        rd(X + 32'h400040, 1'b0, 1'b0);
        chk(hit, 1'b0);
    endtask : t_prog_stall

    task automatic t_stale();
        go <= 1'b0;
        for (int k = 0; k < 9; k++)
            rd(P + k * 32'h10000, 1'b0, 1'b0);
        go <= 1'b1;
        cyc(2);
        go <= 1'b0;
        rd(P + 32'h80040, 1'b0, 1'b0);
        chk(hit, 1'b0);
        go <= 1'b1;
        cyc(40);
        rd(P + 32'h80080, 1'b0, 1'b0);
        chk(hit, 1'b1);
        rd(P + 32'h40, 1'b0, 1'b0);
        chk(hit, 1'b0);
    endtask : t_stale

    task automatic t_mar();
        c0 = cnt;
        rd(32'h01000000, 1'b0, 1'b0);
        req(0, 0, 0);
        rd(32'h0F000000, 1'b0, 1'b0);
        req(2, 32'h0F000080, 32'h0F000040);
        supervisor_i <= 1'b0;
        wmar(4'hC, 1'b0);
        rd(X + 32'h500000, 1'b0, 1'b0);
        req(2, X + 32'h500080, X + 32'h500040);
        supervisor_i <= 1'b1;
        wmar(4'hC, 1'b0);
        rd(X + 32'h600000, 1'b0, 1'b0);
        req(0, 0, 0);
        wmar(4'h1, 1'b1);
        rd(32'h01100000, 1'b0, 1'b0);
        req(2, 32'h01100080, 32'h01100040);
    endtask : t_mar

    initial
    begin
        cyc(12);
        resetn_i <= 1'b1;
        cyc(2);
        t_l1();
        t_l2();
        t_prog_stall();
        t_stale();
        t_mar();
        report_and_stop();
    end

    initial
    begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule : dpsb_tb_top
`default_nettype wire
